// File: core/chseq_channel.sv
// one serial channel: sequence control, event status and bus engine
//
// Overview of operation
// - idle single-shot go starts START plus sequence
// - go writes ignored while single-shot active
// - halt now in read: NACK byte, STOP
// - halt now in write: finish ACK, STOP
// - halt now in single-shot sets sequence finished
// - loop idle gap or trigger active: halt ends at once
// - halt after frame in repeat loop: STOP at frame end, both flags
// - halt now in repeat loop: stop behaviour, both flags
// - STOP to next START with go is loop idle
// - controller status bits 5:3 show channel active
// - 8-bit event register drives active-low interrupt
// - reading event register clears the interrupt
// - buffer event cleared by controller status read
// - after clearing only new events set bits
// - bit 7: sequence sent and STOP issued
// - bit 6: repeat count reached, STOP issued
// - bit 5: address or data NACK on write
// - bit 4: address NACK on read
// - bit 3: data line low at START
// - bit 2: clock line stuck low
// - bit 1: START or STOP at illegal point
// - bit 0: sequence longer than pacing interval
// - halt writes ignored while go is zero
// - halt now wins over halt after frame
`timescale 1ns/1ps
module chseq_channel #(
    parameter int SCL_STUCK_CYCLES = chseq_pkg::SCL_STUCK_DEF,
    parameter int CHANNEL          = 0
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [9:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe_n,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    input  wire logic        trigger_in,
    input  wire logic [7:0]  slave_addr_rw,
    input  wire logic [7:0]  seq_len,
    input  wire logic [7:0]  tx_byte,
    output logic             tx_take,
    output logic      [7:0]  rx_data,
    output logic             rx_valid,
    input  wire logic        buffer_event_in,
    output logic             event_irq_n
);
    import chseq_pkg::*;
    localparam int QW = $clog2(QTR_CYCLES);
    localparam int SW = $clog2(SCL_STUCK_CYCLES + 1);

    if (CHANNEL < 0 || CHANNEL > 2) begin : g_bad_channel
        $error("CHANNEL must be 0, 1 or 2");
    end
    if (SCL_STUCK_CYCLES < 2) begin : g_bad_stuck
        $error("SCL_STUCK_CYCLES must be at least 2");
    end

    // pins pass two flops before any logic reads them
    logic [2:0] pins_s;
    logic       scl_s, sda_s, trig_s;
    sync2 #(.W(3)) u_sync (
        .clk   (clk),
        .reset (reset),
        .d     ({trigger_in, sda_in, scl_in}),
        .q     (pins_s)
    );
    assign {trig_s, sda_s, scl_s} = pins_s;

    // ---------------- bus slave ----------------
    logic       ack_q;
    logic       wr_fire, rd_fire;
    logic [7:0] idx, wd, rd_v;
    assign idx         = address[9:2];
    assign wd          = writedata[7:0];
    assign waitrequest = (read || write) && !ack_q;
    assign wr_fire     = write && ack_q && byteenable[0];
    assign rd_fire     = read && ack_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (read || write) && !ack_q;
        end
    end

    // register state
    seq_state_t  state_q;
    logic        go_q, halt_now_q, halt_frame_q, pacing_q;
    logic [7:0]  repeat_q, mask_q, st_q, xfer_q, frames_q;
    logic [15:0] period_q;
    logic        buf_q, ovr_pend_q;
    logic        ctl_wr, start_req, halt_any, loop_mode;

    assign ctl_wr    = wr_fire && idx == IDX_CONTROL;
    assign start_req = ctl_wr && wd[CTL_GO] && state_q == seq_idle;
    assign halt_any  = halt_now_q || halt_frame_q;
    assign loop_mode = pacing_q || repeat_q != REPEAT_RST;

    always_comb begin
        rd_v = 8'h00;
        if (idx == IDX_CONTROL) begin
            rd_v[CTL_GO]         = go_q;
            rd_v[CTL_HALT_NOW]   = halt_now_q;
            rd_v[CTL_HALT_FRAME] = halt_frame_q;
            rd_v[CTL_PACING]     = pacing_q;
        end else if (idx == IDX_CH_EVT) begin
            rd_v = st_q;
        end else if (idx == IDX_MASK) begin
            rd_v = mask_q;
        end else if (idx == IDX_REPEAT) begin
            rd_v = repeat_q;
        end else if (idx == IDX_PERIOD) begin
            rd_v = period_q[7:0];
        end else if (idx == IDX_COUNT) begin
            rd_v = xfer_q;
        end else if (idx == IDX_CTRL_EVT) begin
            rd_v[ACTIVE_LSB + CHANNEL] = go_q;
            rd_v[BUF_BIT]              = buf_q;
        end
    end

    // captured in the wait cycle so a read clears exactly what it returned
    always_ff @(posedge clk) begin
        if (reset) begin
            readdata <= 32'h0000_0000;
        end else if (read && !ack_q) begin
            readdata <= {24'h00_0000, rd_v};
        end
    end

    // mode registers except the mask cannot change while the channel is active
    always_ff @(posedge clk) begin
        if (reset) begin
            pacing_q <= 1'b0;
            repeat_q <= REPEAT_RST;
            period_q <= PERIOD_RST;
            mask_q   <= MASK_RST;
        end else begin
            if (ctl_wr && state_q == seq_idle) begin
                pacing_q <= wd[CTL_PACING];
            end
            if (wr_fire && idx == IDX_REPEAT && state_q == seq_idle) begin
                repeat_q <= wd;
            end
            if (wr_fire && idx == IDX_PERIOD && state_q == seq_idle) begin
                period_q <= {8'h00, wd};
            end
            if (wr_fire && idx == IDX_MASK) begin
                mask_q <= wd;
            end
        end
    end

    // ---------------- sequence control ----------------
    logic pace_tick, launch, kill;
    logic eng_done, eng_abort;
    logic seq_end, set_seq, set_loop, set_ovr;

    assign launch = start_req && !pacing_q ||
                    state_q == seq_loop_idle && pace_tick && !halt_any;
    // trigger loop mid-frame: no STOP, channel drops at once
    assign kill   = state_q == seq_active && pacing_q && halt_any;

    loop_pacer #(.PW(16)) u_pacer (
        .clk       (clk),
        .reset     (reset),
        .enable    (go_q && loop_mode),
        .restart   (launch && !pacing_q),
        .pacing_on (pacing_q),
        .trigger_s (trig_s),
        .period    (period_q),
        .tick      (pace_tick)
    );

    always_comb begin
        seq_end  = 1'b0;
        set_seq  = 1'b0;
        set_loop = 1'b0;
        case (state_q)
            seq_active: begin
                if (kill) begin
                    seq_end  = 1'b1;
                    set_seq  = 1'b1;
                    set_loop = 1'b1;
                end else if (eng_abort) begin
                    seq_end = 1'b1;
                end else if (eng_done && !loop_mode) begin
                    seq_end = 1'b1;
                    set_seq = 1'b1;
                end else if (eng_done && (halt_any || !pacing_q &&
                             repeat_q != 8'h00 &&
                             frames_q + 8'h01 == repeat_q)) begin
                    seq_end  = 1'b1;
                    set_seq  = 1'b1;
                    set_loop = 1'b1;
                end
            end
            seq_loop_idle: begin
                if (halt_any) begin
                    seq_end  = 1'b1;
                    set_seq  = 1'b1;
                    set_loop = 1'b1;
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q  <= seq_idle;
            frames_q <= 8'h00;
        end else begin
            case (state_q)
                seq_idle: begin
                    frames_q <= 8'h00;
                    if (start_req) begin
                        // trigger mode waits for the first edge
                        state_q <= pacing_q ? seq_loop_idle : seq_active;
                    end
                end
                seq_active: begin
                    if (seq_end) begin
                        state_q <= seq_idle;
                    end else if (eng_done) begin
                        state_q  <= seq_loop_idle;
                        frames_q <= frames_q + 8'h01;
                    end
                end
                default: begin
                    if (seq_end) begin
                        state_q <= seq_idle;
                    end else if (launch) begin
                        state_q <= seq_active;
                    end
                end
            endcase
        end
    end

    // go and halt bits drop together when the sequence ends
    always_ff @(posedge clk) begin
        if (reset || seq_end) begin
            go_q         <= 1'b0;
            halt_now_q   <= 1'b0;
            halt_frame_q <= 1'b0;
        end else begin
            if (start_req) begin
                go_q <= 1'b1;
            end
            if (ctl_wr && go_q) begin
                if (wd[CTL_HALT_NOW]) begin
                    halt_now_q <= 1'b1;
                end else if (wd[CTL_HALT_FRAME]) begin
                    halt_frame_q <= 1'b1;
                end
            end
        end
    end

    // a pacing tick during a loop frame means the frame overran
    always_ff @(posedge clk) begin
        if (reset || state_q != seq_active || eng_done) begin
            ovr_pend_q <= 1'b0;
        end else if (pace_tick && loop_mode) begin
            ovr_pend_q <= 1'b1;
        end
    end
    assign set_ovr = eng_done && ovr_pend_q;

    // ---------------- serial engine ----------------
    bus_state_t    bst_q;
    logic [1:0]    ph_q;
    logic [QW-1:0] qdiv_q;
    logic [SW-1:0] stuck_q;
    logic [7:0]    sh_q, left_q, cnt_q;
    logic [2:0]    bit_q;
    logic          scl_low_q, sda_low_q, addr_q, rd_q, nak_q, sda_prev_q;
    logic          qtick, adv, busy, tx_byte_now, halt_mid;
    logic          dae_hit, scl_stuck, misplaced, ack_smp, nak_now;

    assign qtick       = qdiv_q == QW'(QTR_CYCLES - 1);
    assign busy        = bst_q != bus_idle;
    // phase 2 waits for the released clock line (stretching)
    assign adv         = qtick && busy && !(ph_q == 2'd2 && !scl_s);
    assign tx_byte_now = addr_q || !rd_q;
    assign halt_mid    = halt_now_q && !pacing_q;
    assign dae_hit     = adv && bst_q == bus_start && ph_q == 2'd2 &&
                         !sda_s;
    assign scl_stuck   = busy && stuck_q == SW'(SCL_STUCK_CYCLES - 1);
    // sda only moves in phase 0, so an edge in phase 2 is foreign
    assign misplaced   = (bst_q == bus_data || bst_q == bus_ack) &&
                         ph_q == 2'd2 && scl_s && sda_s != sda_prev_q;
    assign ack_smp     = adv && bst_q == bus_ack && ph_q == 2'd2;
    assign nak_now     = ack_smp && tx_byte_now && sda_s;
    assign eng_done    = adv && bst_q == bus_stop && ph_q == 2'd3 &&
                         !kill && !scl_stuck;
    assign eng_abort   = dae_hit || scl_stuck || misplaced;

    always_ff @(posedge clk) begin
        if (reset || !busy || qtick) begin
            qdiv_q <= '0;
        end else begin
            qdiv_q <= qdiv_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || !busy || scl_low_q || scl_s) begin
            stuck_q <= '0;
        end else begin
            stuck_q <= stuck_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sda_prev_q <= 1'b1;
        end else begin
            sda_prev_q <= sda_s;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || kill || eng_abort) begin
            bst_q     <= bus_idle;
            ph_q      <= 2'd0;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            tx_take   <= 1'b0;
            rx_valid  <= 1'b0;
        end else begin
            tx_take  <= 1'b0;
            rx_valid <= 1'b0;
            if (!busy) begin
                ph_q <= 2'd0;
                if (launch) begin
                    bst_q <= bus_start;
                end
            end else if (adv) begin
                ph_q <= ph_q + 2'd1;
                case (bst_q)
                    bus_start: begin
                        if (ph_q == 2'd0) begin
                            scl_low_q <= 1'b0;
                            sda_low_q <= 1'b0;
                        end else if (ph_q == 2'd2) begin
                            sda_low_q <= 1'b1;
                        end else if (ph_q == 2'd3) begin
                            scl_low_q <= 1'b1;
                            sh_q      <= slave_addr_rw;
                            rd_q      <= slave_addr_rw[0];
                            left_q    <= seq_len;
                            addr_q    <= 1'b1;
                            bit_q     <= 3'd0;
                            cnt_q     <= 8'h00;
                            bst_q     <= bus_data;
                        end
                    end
                    bus_data: begin
                        if (ph_q == 2'd0) begin
                            sda_low_q <= tx_byte_now && !sh_q[7];
                        end else if (ph_q == 2'd1) begin
                            scl_low_q <= 1'b0;
                        end else if (ph_q == 2'd2) begin
                            sh_q <= {sh_q[6:0], sda_s};
                        end else begin
                            scl_low_q <= 1'b1;
                            bit_q     <= bit_q + 3'd1;
                            if (bit_q == 3'd7) begin
                                bst_q <= bus_ack;
                            end
                        end
                    end
                    bus_ack: begin
                        if (ph_q == 2'd0) begin
                            // last byte or halt: NACK the read byte
                            sda_low_q <= !tx_byte_now && left_q != 8'h01 &&
                                         !halt_mid;
                        end else if (ph_q == 2'd1) begin
                            scl_low_q <= 1'b0;
                        end else if (ph_q == 2'd2) begin
                            nak_q <= tx_byte_now && sda_s;
                            if (!tx_byte_now) begin
                                rx_data  <= sh_q;
                                rx_valid <= 1'b1;
                            end
                        end else begin
                            scl_low_q <= 1'b1;
                            addr_q    <= 1'b0;
                            if (!addr_q) begin
                                left_q <= left_q - 8'h01;
                            end
                            if (!addr_q && !nak_q) begin
                                cnt_q <= cnt_q + 8'h01;
                            end
                            if (nak_q || halt_mid ||
                                (addr_q ? left_q == 8'h00
                                        : left_q == 8'h01)) begin
                                bst_q <= bus_stop;
                            end else begin
                                bst_q <= bus_data;
                                if (!rd_q) begin
                                    sh_q    <= tx_byte;
                                    tx_take <= 1'b1;
                                end
                            end
                        end
                    end
                    default: begin
                        if (ph_q == 2'd0) begin
                            sda_low_q <= 1'b1;
                        end else if (ph_q == 2'd1) begin
                            scl_low_q <= 1'b0;
                        end else if (ph_q == 2'd2) begin
                            sda_low_q <= 1'b0;
                        end else begin
                            bst_q <= bus_idle;
                        end
                    end
                endcase
            end
        end
    end

    // transferred count is published when the STOP completes
    always_ff @(posedge clk) begin
        if (reset) begin
            xfer_q <= 8'h00;
        end else if (eng_done) begin
            xfer_q <= cnt_q;
        end
    end

    assign scl_out  = 1'b0;
    assign sda_out  = 1'b0;
    assign scl_oe_n = !scl_low_q;
    assign sda_oe_n = !sda_low_q;

    // ---------------- event status ----------------
    logic [7:0] set_v, clr_v;
    logic       buf_clr;
    assign set_v = {set_seq, set_loop,
                    nak_now && !(addr_q && rd_q),
                    nak_now && addr_q && rd_q,
                    dae_hit, scl_stuck, misplaced, set_ovr};
    assign clr_v   = (rd_fire && idx == IDX_CH_EVT) ? readdata[7:0]
                                                    : 8'h00;
    assign buf_clr = rd_fire && idx == IDX_CTRL_EVT && readdata[BUF_BIT];

    // set wins over clear; only bits returned by the read are cleared
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q  <= 8'h00;
            buf_q <= 1'b0;
        end else begin
            st_q  <= (st_q & ~clr_v) | set_v;
            buf_q <= (buf_q && !buf_clr) || buffer_event_in;
        end
    end

    // bits 3:1 (data low at START, clock stuck, misplaced) ignore the mask
    always_ff @(posedge clk) begin
        if (reset) begin
            event_irq_n <= 1'b1;
        end else begin
            event_irq_n <= !((|(st_q & ~(mask_q & ~NMI_BITS))) ||
                             buf_q);
        end
    end
endmodule

// File: core/chseq_pkg.sv
// constants, register map and state types for the channel sequencer
package chseq_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_PERIOD_NS = 1000;
    // four phases per serial bit; a longest time, so it rounds down
    localparam int QTR_CYCLES    = BIT_PERIOD_NS / (4 * CLK_PERIOD_NS);
    // refresh period unit
    localparam int UNIT_NS       = 1000;
    localparam int UNIT_CYCLES   = UNIT_NS / CLK_PERIOD_NS;
    // clock line low this long counts as stuck; a least time, rounds up
    localparam int SCL_STUCK_US  = 1000;
    localparam int SCL_STUCK_DEF =
        (SCL_STUCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL_EVT = 8'h02;
    localparam logic [7:0] IDX_CONTROL  = 8'hc0;
    localparam logic [7:0] IDX_CH_EVT   = 8'hc1;
    localparam logic [7:0] IDX_MASK     = 8'hc2;
    localparam logic [7:0] IDX_REPEAT   = 8'hc3;
    localparam logic [7:0] IDX_PERIOD   = 8'hc4;
    localparam logic [7:0] IDX_COUNT    = 8'hc5;

    // control register fields
    localparam int CTL_HALT_FRAME = 7;
    localparam int CTL_GO         = 6;
    localparam int CTL_HALT_NOW   = 5;
    localparam int CTL_PACING     = 3;

    // channel event register fields
    localparam int SB_SEQ   = 7;
    localparam int SB_LOOP  = 6;
    localparam int SB_WNAK  = 5;
    localparam int SB_RNAK  = 4;
    localparam int SB_SDA   = 3;
    localparam int SB_SCL   = 2;
    localparam int SB_MISPL = 1;
    localparam int SB_OVR   = 0;
    localparam logic [7:0] NMI_BITS = 8'h0e;

    // controller event register fields
    localparam int ACTIVE_LSB = 3;
    localparam int BUF_BIT    = 0;

    localparam logic [7:0]  REPEAT_RST = 8'h01;
    localparam logic [7:0]  MASK_RST   = 8'h00;
    localparam logic [15:0] PERIOD_RST = 16'h0064;

    typedef enum logic [1:0] {
        seq_idle, seq_active, seq_loop_idle
    } seq_state_t;
    typedef enum logic [2:0] {
        bus_idle, bus_start, bus_data, bus_ack, bus_stop
    } bus_state_t;
endpackage

// File: core/loop_pacer.sv
// frame pacing: refresh-period timer or trigger edge
`timescale 1ns/1ps
module loop_pacer #(
    parameter int PW = 16
) (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          enable,
    input  wire logic          restart,
    input  wire logic          pacing_on,
    input  wire logic          trigger_s,
    input  wire logic [PW-1:0] period,
    output logic               tick
);
    import chseq_pkg::*;
    localparam int UW = $clog2(UNIT_CYCLES);

    logic [UW-1:0] unit_q;
    logic [PW-1:0] per_q;
    logic          trig_q;
    logic          unit_en;
    logic          per_hit;

    assign unit_en = unit_q == UW'(UNIT_CYCLES - 1);
    // a zero period behaves as one unit
    assign per_hit = unit_en && (per_q + 1'b1 >= period);

    always_ff @(posedge clk) begin
        if (reset || restart || !enable || unit_en) begin
            unit_q <= '0;
        end else begin
            unit_q <= unit_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || restart || !enable || per_hit) begin
            per_q <= '0;
        end else if (unit_en) begin
            per_q <= per_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            trig_q <= 1'b0;
            tick   <= 1'b0;
        end else begin
            trig_q <= trigger_s;
            tick   <= enable && (pacing_on ? (trigger_s && !trig_q)
                                           : per_hit);
        end
    end
endmodule

// File: core/sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// File: test/chseq_checker.sv
// port assertions for the channel sequencer
`timescale 1ns/1ps
module chseq_checker (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [9:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        scl_oe_n,
    input wire logic        tx_take,
    input wire logic        rx_valid,
    input wire logic        buffer_event_in,
    input wire logic        event_irq_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence one_wait;
        waitrequest ##1 !waitrequest;
    endsequence
    wait_rd_a: assert property ($rose(read) |-> one_wait)
        else $error("read wait state wrong");
    wait_wr_a: assert property ($rose(write) |-> one_wait)
        else $error("write wait state wrong");
    upper_zero_a: assert property (read && !waitrequest |->
        readdata[31:8] == '0) else $error("upper read bits set");
    unmapped_zero_a: assert property (read && !waitrequest &&
        address[9:6] == 4'h1 |-> readdata == '0)
        else $error("unmapped read not zero");
    take_pulse_a: assert property (tx_take |=> !tx_take)
        else $error("byte take longer than a cycle");
    rx_pulse_a: assert property (rx_valid |=> !rx_valid)
        else $error("receive strobe longer than a cycle");
    // two low quarters of a bit plus margin
    scl_low_a: assert property ($fell(scl_oe_n) |-> ##[1:120] scl_oe_n)
        else $error("clock line held low too long");
    buf_irq_a: assert property (buffer_event_in |-> ##[1:3] !event_irq_n)
        else $error("buffer event raised no interrupt");
endmodule
bind chseq_channel chseq_checker chk_u (.clk, .reset, .address, .read,
    .write, .readdata, .waitrequest, .scl_oe_n, .tx_take, .rx_valid,
    .buffer_event_in, .event_irq_n);

// File: test/i2c_slave_model.sv
// behavioural serial slave: acknowledges bytes or refuses them
`timescale 1ns/1ps
module i2c_slave_model (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic nack,
    output logic      sda_pull_n
);
    int bits = 0;
    initial sda_pull_n = 1'b1;
    always @(negedge sda) if (scl) bits = -1;
    // pull only in the ack slot; the pull-up holds the line otherwise
    always @(negedge scl) begin
        bits = bits + 1;
        sda_pull_n = !(bits == 8 && !nack);
        if (bits == 9) bits = 0;
    end
endmodule

// File: test/tb_top.sv
// self-checking bench for one channel sequencer
`timescale 1ns/1ps
module tb_top;
    import chseq_pkg::*;
    logic        clk = 0, reset = 1, read = 0, write = 0, trig = 0;
    logic        trig_en = 0, nack = 0, buf_ev = 0;
    logic [9:0]  address = '0;
    logic [31:0] writedata = '0, readdata;
    logic [7:0]  sar = '0, txb = '0, q;
    logic        waitrequest, scl_oe_n, sda_oe_n, irq_n, pull_n;
    int          n_errors = 0, checked = 0;
    int          cases[$] = '{0, 1, 3};
    wire         scl = scl_oe_n;
    wire         sda = sda_oe_n & pull_n;
    chseq_channel #(.SCL_STUCK_CYCLES(200)) dut_u (.clk, .reset, .address,
        .read, .write, .writedata, .byteenable(4'h1), .readdata,
        .waitrequest, .scl_in(scl), .scl_out(), .scl_oe_n, .sda_in(sda),
        .sda_out(), .sda_oe_n, .trigger_in(trig), .slave_addr_rw(sar),
        .seq_len(8'h01), .tx_byte(txb), .tx_take(), .rx_data(),
        .rx_valid(), .buffer_event_in(buf_ev), .event_irq_n(irq_n));
    i2c_slave_model slave_u (.scl, .sda, .nack, .sda_pull_n(pull_n));
    initial forever #5 clk = ~clk;
    always #40 trig = trig_en & ~trig;
    task automatic bus(input logic [7:0] i, input logic w,
                       input logic [7:0] d);
        @(posedge clk);
        address   <= {i, 2'b00};
        read      <= !w;
        write     <= w;
        writedata <= {24'h00_0000, d};
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read  <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checked %0d, errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    function automatic logic [7:0] evt_of(int c);
        if (c[0]) return c[1] ? 8'(1 << SB_RNAK) : 8'(1 << SB_WNAK);
        return 8'(1 << SB_SEQ);
    endfunction
    initial begin
        #200_000;
        n_errors++;
        give_verdict;
    end
    initial begin
        void'($urandom(39665));
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        bus(IDX_REPEAT, 0, 0);
        chk(q, REPEAT_RST);
        bus(8'h10 + 8'($urandom % 16), 0, 0);
        chk(q, 8'h00);
        bus(IDX_CONTROL, 1, 8'(1 << CTL_HALT_NOW));
        bus(IDX_CONTROL, 0, 0);
        chk(q, 8'h00);
        bus(IDX_CH_EVT, 0, 0);
        chk(q, 8'h00);
        $display("reset and idle test done");
        foreach (cases[i]) begin
            nack <= cases[i][0];
            sar  <= {7'($urandom), cases[i][1]};
            txb  <= 8'($urandom);
            bus(IDX_CONTROL, 1, 8'(1 << CTL_GO));
            bus(IDX_CONTROL, 1, 8'h00);
            bus(IDX_CTRL_EVT, 0, 0);
            chk(8'(q[ACTIVE_LSB]), 8'h01);
            do bus(IDX_CTRL_EVT, 0, 0); while (q[ACTIVE_LSB] === 1'b1);
            repeat (3) @(posedge clk);
            chk(8'(irq_n), 8'h00);
            bus(IDX_CH_EVT, 0, 0);
            chk(q & (cases[i][0] ? 8'h30 : 8'hff), evt_of(cases[i]));
            bus(IDX_CH_EVT, 0, 0);
            chk(q, 8'h00);
            chk(8'(irq_n), 8'h01);
            bus(IDX_COUNT, 0, 0);
            chk(q, 8'(cases[i] == 0));
            $display("frame test %0d done", i);
        end
        nack    <= 1'b0;
        trig_en <= 1'b1;
        bus(IDX_CONTROL, 1, 8'(1 << CTL_PACING));
        bus(IDX_CONTROL, 1, 8'(1 << CTL_GO | 1 << CTL_PACING));
        repeat (400) @(posedge clk);
        bus(IDX_CONTROL, 1, 8'he8);
        bus(IDX_CTRL_EVT, 0, 0);
        chk(8'(q[ACTIVE_LSB]), 8'h00);
        bus(IDX_CH_EVT, 0, 0);
        chk(q & 8'hc0, 8'hc0);
        trig_en <= 1'b0;
        buf_ev  <= 1'b1;
        @(posedge clk);
        buf_ev <= 1'b0;
        bus(IDX_CTRL_EVT, 0, 0);
        chk(8'(q[BUF_BIT]), 8'h01);
        bus(IDX_CTRL_EVT, 0, 0);
        chk(8'(q[BUF_BIT]), 8'h00);
        $display("loop and buffer test done");
        give_verdict;
    end
endmodule
